// [test/lasq_checker.sv]
// checker of the link between the array section and its controller
// assumes plain inputs wired from the link interface in the bench top
`timescale 1ns/1ps

module lasq_checker #(
   parameter int XFER_CYC_P = lasq_pkg::XFER_CYC,
   parameter int SPACING_MAX_P = lasq_pkg::SPACING_MAX_CYC
) (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // link
   input wire logic si,
   input wire logic hold,
   input wire logic pclk,
   input wire logic [15:0] aout_data,
   input wire logic aout_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // ************************************************************
   // helper counters
   // ************************************************************
   logic pclk_q, si_q;           // previous samples
   logic [9:0] rise_q, rise_d;   // pixel clock rises since start
   logic [24:0] gap_q, gap_d;    // cycles since the last start
   logic [15:0] xfer_q, xfer_d;  // cycles since rise n+1
   logic [5:0] hi_q, hi_d;       // length of the present pclk level
   logic rise, start;
   assign rise = pclk && !pclk_q;
   assign start = si && !si_q;

   // next values; all counters but gap_q saturate so long idles cannot wrap them; gap_q wraps
   always_comb begin
      rise_d = rise_q;
      if (rise && si) begin
         rise_d = 10'h001;
      end else if (rise && rise_q != 10'h3ff) begin
         rise_d = rise_q + 10'h001;
      end
      gap_d = start ? 25'h0000000 : gap_q + 25'h0000001;
      xfer_d = (xfer_q == 16'hffff) ? xfer_q : xfer_q + 16'h0001;
      if (rise && rise_q == lasq_pkg::PIX_LAST) begin
         xfer_d = 16'h0000;
      end
      hi_d = (pclk != pclk_q) ? 6'h01 : ((hi_q == 6'h3f) ? hi_q : hi_q + 6'h01);
   end

   // registers only; reset values let the first start pass
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pclk_q <= 1'b0;
         si_q <= 1'b0;
         rise_q <= 10'h000;
         gap_q <= 25'h0000000;
         xfer_q <= 16'hffff;
         hi_q <= 6'h3f;
      end else begin
         pclk_q <= pclk;
         si_q <= si;
         rise_q <= rise_d;
         gap_q <= gap_d;
         xfer_q <= xfer_d;
         hi_q <= hi_d;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   hold_follows_si_a: assert property (hold == si)
      else $error("hold strobe differs from start");
   start_spacing_a: assert property (start |-> rise_q == 10'h000
      || rise_q >= lasq_pkg::PIX_END)
      else $error("start before n+1 clocks");
   start_late_a: assert property (start |-> xfer_q >= XFER_CYC_P)
      else $error("start inside charge transfer time");
   spacing_max_a: assert property (gap_q < SPACING_MAX_P)
      else $error("start spacing too long");
   si_short_a: assert property (rise && si |-> ##[1:40] !si)
      else $error("start held too long");
   first_pixel_a: assert property (rise && si |-> ##[1:2] !aout_oe_n)
      else $error("pixel output not driven at start");
   pixel_step_a: assert property (rise && !si && rise_q inside {[1:639]}
      |-> ##[1:2] $changed(aout_data))
      else $error("next pixel not presented");
   float_end_a: assert property (rise && !si && rise_q == lasq_pkg::PIX_LAST
      |-> ##[1:2] aout_oe_n)
      else $error("output not floated at clock n+1");
   word_hold_a: assert property (!aout_oe_n && !$past(aout_oe_n) && !$past(rise)
      && !$past(rise, 2) |-> $stable(aout_data))
      else $error("pixel word changed inside its period");
   clk_rate_a: assert property (pclk != pclk_q |-> hi_q >= lasq_pkg::PX_HALF_CYC)
      else $error("pixel clock phase too short");
   idle_low_a: assert property (rise_q == lasq_pkg::PIX_END && !pclk && !si |=> !pclk)
      else $error("pixel clock left idle high");

   // main scenarios reached
   start_seen_c: cover property (start);
   float_seen_c: cover property (rise && rise_q == lasq_pkg::PIX_LAST);
   stall_seen_c: cover property (!pclk && hi_q == 6'h3f);
endmodule : lasq_checker

// [test/linear_array_scan_sequencer_tb.sv]
// testbench of the scan sequencer: both ends joined through the link
// assumes the design files are compiled first; counts are shortened
`timescale 1ns/1ps

module linear_array_scan_sequencer_tb;
   // ************************************************************
   // stimulus and bookkeeping
   // ************************************************************
   localparam int XFER_T = 20;                 // short charge transfer
   localparam int MAX_T = 30000;               // short spacing ceiling
   localparam logic [24:0] WAIT_T = 25'h0005208; // 21000 cycles a scan
   logic clk_sys, resetn, run_en, px_ready;
   logic [24:0] wait_cyc, integ_cyc, exp_integ;
   logic [7:0] light_level;
   logic scan_done, px_valid, integrator_reset_switch, pclk_seen;
   logic [15:0] px_data;
   logic [9:0] sample_switch_resumed;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;

   lasq_link_if lasq_link_if_i ();
   lasq_sensor lasq_sensor_i (.clk_sys(clk_sys), .resetn(resetn), .link(lasq_link_if_i),
      .light_level(light_level), .integrator_reset_switch(integrator_reset_switch),
      .sample_switch_resumed(sample_switch_resumed));
   lasq_ctrl #(.XFER_CYC_P(XFER_T), .SPACING_MAX_P(MAX_T)) lasq_ctrl_i (.clk_sys(clk_sys),
      .resetn(resetn), .link(lasq_link_if_i), .run_en(run_en), .wait_cyc(wait_cyc),
      .scan_done(scan_done), .integ_cyc(integ_cyc), .px_valid(px_valid),
      .px_ready(px_ready), .px_data(px_data));
   lasq_checker #(.XFER_CYC_P(XFER_T), .SPACING_MAX_P(MAX_T)) lasq_checker_i (
      .clk_sys(clk_sys), .resetn(resetn), .si(lasq_link_if_i.si),
      .hold(lasq_link_if_i.hold), .pclk(lasq_link_if_i.pclk),
      .aout_data(lasq_link_if_i.aout_data), .aout_oe_n(lasq_link_if_i.aout_oe_n));

   // 250 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // hang guard, well above three scans
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         wrap_up();
      end
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : chk

   // counts pixel clock rises, then lets the answer settle
   task automatic wait_rises(input int n);
      int k;
      k = 0;
      while (k < n) begin
         @(negedge clk_sys);
         if (lasq_link_if_i.pclk === 1'b1 && pclk_seen === 1'b0) k++;
         pclk_seen = lasq_link_if_i.pclk;
      end
      repeat (3) @(negedge clk_sys);
   endtask : wait_rises

   // takes one scan from the stream, word k being held ^ k
   task automatic collect(input logic [15:0] held);
      logic [15:0] k;
      k = 16'h0001;
      while (k <= 16'h0280) begin
         @(negedge clk_sys);
         if (px_valid === 1'b1 && px_ready === 1'b1) begin
            chk(px_data === (held ^ k), "pixel word wrong");
            k++;
         end
      end
   endtask : collect

   // switch sequence of one scan, from its start rise to rise n+1
   task automatic setup_check();
      pclk_seen = lasq_link_if_i.pclk;
      wait_rises(1);
      chk(integrator_reset_switch === 1'b1 && sample_switch_resumed === 10'h000, "start");
      chk(lasq_link_if_i.aout_oe_n === 1'b0, "output not driven");
      wait_rises(17);
      chk(integrator_reset_switch === 1'b1, "reset left early");
      wait_rises(1);
      chk(integrator_reset_switch === 1'b0, "reset kept at clock 19");
      chk(sample_switch_resumed === 10'h012, "pixels 1 to 18 not sampling");
      wait_rises(1);
      chk(sample_switch_resumed === 10'h013, "pixel 19 not sampling");
      wait_rises(621);
      chk(sample_switch_resumed === 10'h280, "last pixel not sampling");
      chk(lasq_link_if_i.aout_oe_n === 1'b1, "output not floating");
   endtask : setup_check

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up

   // ************************************************************
   // scenarios
   // ************************************************************
   // first scan after reset is dark and must not reach the stream
   task automatic flush_scan();
      int pushes;
      pushes = 0;
      @(posedge clk_sys);
      run_en <= 1'b1;
      while (lasq_link_if_i.si !== 1'b1) @(negedge clk_sys);
      while (lasq_link_if_i.si !== 1'b0) @(negedge clk_sys);
      while (lasq_link_if_i.si !== 1'b1) begin
         @(negedge clk_sys);
         if (px_valid === 1'b1) pushes++;
      end
      chk(pushes == 0, "flush scan reached the stream");
   endtask : flush_scan

   // dark data read out while a bright exposure integrates
   task automatic scan_plain();
      fork
         collect(16'h0000);
         setup_check();
         // light only once the start has held the dark charge
         begin
            while (integrator_reset_switch !== 1'b1) @(negedge clk_sys);
            @(posedge clk_sys);
            light_level <= 8'hff;
         end
      join
      while (scan_done !== 1'b1) @(negedge clk_sys);
      // start stands half a clock period before its rising edge
      exp_integ = WAIT_T + 25'(lasq_pkg::PX_HALF_CYC) - lasq_pkg::SETUP_CYC;
      chk(integ_cyc + 25'h2 >= exp_integ && integ_cyc <= exp_integ + 25'h2, "integ");
   endtask : scan_plain

   // stream stalled until the buffer refuses, then drained empty
   task automatic scan_stall();
      int still;
      still = 0;
      @(posedge clk_sys);
      px_ready <= 1'b0;
      while (px_valid !== 1'b1) @(negedge clk_sys);
      repeat (1000) @(negedge clk_sys);
      repeat (200) begin
         @(negedge clk_sys);
         if (lasq_link_if_i.pclk === 1'b0 && px_valid === 1'b1) still++;
      end
      chk(still == 200, "pixel clock ran with buffer full");
      @(posedge clk_sys);
      px_ready <= 1'b1;
      collect(16'hffff);
      repeat (2) @(negedge clk_sys);
      chk(px_valid === 1'b0, "buffer not empty after drain");
   endtask : scan_stall

   // main sequence
   initial begin
      resetn = 1'b0;
      run_en = 1'b0;
      px_ready = 1'b1;
      wait_cyc = WAIT_T;
      light_level = 8'h00;
      exp_integ = 25'h0000000;
      pclk_seen = 1'b0;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      flush_scan();
      scan_plain();
      scan_stall();
      wrap_up();
   end
endmodule : linear_array_scan_sequencer_tb

// [verilog/lasq_ctrl.sv]
// controller end: start, hold and pixel clock generation, pixel capture
// assumes the section answers on the same clk_sys; holds a 16-word FIFO
`timescale 1ns/1ps

// ************************************************************
// pixel buffer
// ************************************************************
module lasq_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];            // storage entries
   logic [AW-1:0] wp_q, wp_d;          // write index
   logic [AW-1:0] rp_q, rp_d;          // read index
   logic [AW:0] cnt_q, cnt_d;          // words held
   logic full_q, full_d;
   logic empty_q, empty_d;
   logic wr, rd;

   // pointer and flag update
   always_comb begin
      wr = in_valid & ~full_q;
      rd = out_ready & ~empty_q;
      wp_d = wr ? wp_q + AW'(1) : wp_q;
      rp_d = rd ? rp_q + AW'(1) : rp_q;
      cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
      full_d = cnt_d == (AW+1)'(D);
      empty_d = cnt_d == '0;
   end

   // one write port per entry
   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk_sys) begin
         if (wr && wp_q == AW'(i)) begin
            mem_q[i] <= in_data;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
         empty_q <= empty_d;
      end
   end

   assign in_ready = ~full_q;
   assign out_valid = ~empty_q;
   assign out_data = mem_q[rp_q];
endmodule : lasq_fifo

// ************************************************************
// controller
// ************************************************************
// Functional notes
// - integration is start spacing minus 18 clocks
// - start high at clock edge launches cycle
// - at least n+1 clocks between starts
// - optional idle wait, spacing at most 100 ms
// - start captures all pixels, pixel 1 out
// - each clock presents the next pixel
// - integrators reset during start plus 17 clocks
// - 19th clock releases reset, integration begins
// - first 18 pixels output during reset
// - pixel resumes sampling one clock after readout
// - clock n+1: last resumes, output floats
// - wait 20 us transfer before next start
// - pixel clock no faster than 8 MHz
// - first scan after power up is discarded
// - park the clock low while idle
// - integration between minimum and 100 ms
// - previous data read while next integrates
// - pixel valid for the whole clock period
// - start low before the following rising edge
module lasq_ctrl #(
   parameter int XFER_CYC_P = lasq_pkg::XFER_CYC,
   parameter int SPACING_MAX_P = lasq_pkg::SPACING_MAX_CYC
) (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // link
   lasq_link_if.ctl link,
   // scan control
   input wire logic run_en,
   input wire logic [24:0] wait_cyc,
   output logic scan_done,
   output logic [24:0] integ_cyc,
   // pixel stream
   output logic px_valid,
   input wire logic px_ready,
   output logic [15:0] px_data
);

   // ************************************************************
   // state
   // ************************************************************
   lasq_pkg::lasq_state_t st_q, st_d;   // sequence step
   logic [24:0] tmr_q, tmr_d;           // time in the current step
   logic [24:0] sp_q, sp_d;             // time since the last start
   logic [9:0] rise_q, rise_d;          // rising edges since start
   logic si_q, si_d;                    // start and hold line
   logic pclk_q, pclk_d;                // pixel clock line
   logic flush_q, flush_d;              // power-up scan in progress
   logic done_q, done_d;                // scan finished pulse
   logic [24:0] integ_q, integ_d;       // last integration length
   logic push, fifo_rdy, half_done, may_start;

   // ************************************************************
   // buffer between the link and the user
   // ************************************************************
   lasq_fifo #(.W(lasq_pkg::DW), .D(lasq_pkg::FIFO_DEPTH)) lasq_fifo_i (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .in_valid(push),
      .in_ready(fifo_rdy),
      .in_data(link.aout_data),
      .out_valid(px_valid),
      .out_ready(px_ready),
      .out_data(px_data)
   );

   // ************************************************************
   // sequence
   // ************************************************************
   // the clock is held low while the buffer is full; a slower clock is
   // always legal, but a long stall stretches the start spacing
   always_comb begin
      half_done = tmr_q >= 25'(lasq_pkg::PX_HALF_CYC - 1);
      // next start once the wanted wait is over, or just before the limit
      may_start = sp_q >= wait_cyc ||
                  sp_q >= 25'(SPACING_MAX_P - lasq_pkg::PX_HALF_CYC - 2);
      push = 1'b0;
      st_d = st_q;
      tmr_d = tmr_q + 25'h0000001;
      sp_d = (sp_q == 25'h1ffffff) ? sp_q : sp_q + 25'h0000001;
      rise_d = rise_q;
      si_d = si_q;
      pclk_d = pclk_q;
      flush_d = flush_q;
      done_d = 1'b0;
      integ_d = integ_q;
      case (st_q)
         lasq_pkg::ST_IDLE: begin
            pclk_d = 1'b0;
            if (run_en) begin
               st_d = lasq_pkg::ST_SETUP;
               si_d = 1'b1;
               tmr_d = 25'h0000000;
            end
         end
         lasq_pkg::ST_SETUP: begin
            // start stands half a period before the rising edge
            if (half_done) begin
               pclk_d = 1'b1;
               rise_d = 10'h001;
               st_d = lasq_pkg::ST_CLK_HI;
               tmr_d = 25'h0000000;
               sp_d = 25'h0000000;
               if (!flush_q) begin
                  integ_d = sp_q - lasq_pkg::SETUP_CYC;
               end
            end
         end
         lasq_pkg::ST_CLK_HI: begin
            if (half_done) begin
               pclk_d = 1'b0;
               si_d = 1'b0;
               st_d = lasq_pkg::ST_CLK_LO;
               tmr_d = 25'h0000000;
            end
         end
         lasq_pkg::ST_CLK_LO: begin
            if (rise_q == lasq_pkg::PIX_END) begin
               // last pixel left; the output floats now
               st_d = lasq_pkg::ST_XFER;
               tmr_d = 25'h0000000;
            end else if (half_done && (flush_q || fifo_rdy)) begin
               // pixel rise_q is sampled late in its own period
               push = ~flush_q & ~link.aout_oe_n;
               pclk_d = 1'b1;
               rise_d = rise_q + 10'h001;
               st_d = lasq_pkg::ST_CLK_HI;
               tmr_d = 25'h0000000;
            end else begin
               tmr_d = half_done ? tmr_q : tmr_d;
            end
         end
         lasq_pkg::ST_XFER: begin
            if (tmr_q >= 25'(XFER_CYC_P - 1)) begin
               st_d = lasq_pkg::ST_WAIT;
               done_d = ~flush_q;
               flush_d = 1'b0;
            end
         end
         lasq_pkg::ST_WAIT: begin
            if (!run_en) begin
               st_d = lasq_pkg::ST_IDLE;
            end else if (may_start) begin
               st_d = lasq_pkg::ST_SETUP;
               si_d = 1'b1;
               tmr_d = 25'h0000000;
            end
         end
         default: begin
            st_d = lasq_pkg::ST_IDLE;
            si_d = 1'b0;
            pclk_d = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q <= lasq_pkg::ST_IDLE;
         tmr_q <= 25'h0000000;
         sp_q <= 25'h0000000;
         rise_q <= 10'h000;
         si_q <= 1'b0;
         pclk_q <= 1'b0;
         flush_q <= 1'b1;
         done_q <= 1'b0;
         integ_q <= 25'h0000000;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         sp_q <= sp_d;
         rise_q <= rise_d;
         si_q <= si_d;
         pclk_q <= pclk_d;
         flush_q <= flush_d;
         done_q <= done_d;
         integ_q <= integ_d;
      end
   end

   // start and hold are tied together, the usual wiring
   assign link.si = si_q;
   assign link.hold = si_q;
   assign link.pclk = pclk_q;
   assign scan_done = done_q;
   assign integ_cyc = integ_q;

endmodule : lasq_ctrl

// [verilog/lasq_link_if.sv]
// link between the array section and its controller
// assumes both ends run on clk_sys; the output enable marks a floating pin
`timescale 1ns/1ps

interface lasq_link_if;
   logic si;                        // start pulse
   logic hold;                      // hold strobe, tied to start
   logic pclk;                      // pixel clock level
   logic [15:0] aout_data;          // analog_pixel_out as a word
   logic aout_oe_n;                 // low while the section drives

   modport dev (input si, hold, pclk, output aout_data, aout_oe_n);
   modport ctl (output si, hold, pclk, input aout_data, aout_oe_n);
endinterface : lasq_link_if

// [verilog/lasq_pkg.sv]
// shared constants and types of the linear array scan sequencer
// assumes one system clock of 250 MHz feeding both ends of the link

package lasq_pkg;

   // ************************************************************
   // array geometry
   // ************************************************************
   localparam int PIX_N = 640;                   // pixels scanned per start
   localparam int IDX_W = 10;                    // wide enough for PIX_N + 1
   localparam logic [9:0] PIX_LAST = 10'h280;    // index of pixel n
   localparam logic [9:0] PIX_END = 10'h281;     // clock n+1, output floats
   localparam logic [9:0] SETUP_CLKS = 10'h012;  // clocks spent in setup (18)
   localparam logic [9:0] RELEASE_CLK = 10'h013; // clock that ends reset (19)
   localparam int DW = 16;                       // pixel word width
   localparam int LW = 8;                        // light level width

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ = 250_000_000;          // system clock rate
   localparam int PX_MAX_HZ = 8_000_000;         // fastest pixel clock
   localparam int PX_PERIOD_CYC = (CLK_HZ + PX_MAX_HZ - 1) / PX_MAX_HZ;
   localparam int PX_HALF_CYC = PX_PERIOD_CYC / 2;
   localparam int XFER_US = 20;                  // charge transfer time, us
   localparam int XFER_CYC = XFER_US * (CLK_HZ / 1_000_000);
   localparam int SPACING_MAX_MS = 100;          // longest start spacing, ms
   localparam int SPACING_MAX_CYC = SPACING_MAX_MS * (CLK_HZ / 1000);
   localparam int TW = 25;                       // timer width
   localparam logic [24:0] SETUP_CYC = 25'(18 * PX_PERIOD_CYC);

   // ************************************************************
   // buffering and reset values
   // ************************************************************
   localparam int FIFO_DEPTH = 16;
   localparam logic [15:0] ACC_RST = 16'h0000;
   localparam logic [15:0] ACC_MAX = 16'hffff;

   // controller sequence
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_CLK_HI = 3'h2,
      ST_CLK_LO = 3'h3,
      ST_XFER = 3'h4,
      ST_WAIT = 3'h5
   } lasq_state_t;

endpackage : lasq_pkg

// [verilog/lasq_sensor.sv]
// array section end: sequencing of sample, hold and integrator switches
// assumes the controller keeps its own timing limits on start and clock
`timescale 1ns/1ps

module lasq_sensor (
   // system
   input wire logic clk_sys,
   input wire logic resetn,
   // link
   lasq_link_if.dev link,
   // user side
   input wire logic [7:0] light_level,
   output logic integrator_reset_switch,
   output logic [9:0] sample_switch_resumed
);

   // ************************************************************
   // state
   // ************************************************************
   logic pclk_prev_q, pclk_prev_d;  // last pixel clock level
   logic [9:0] cnt_q, cnt_d;        // clocks since start, 0 when idle
   logic [15:0] acc_q, acc_d;       // integrating capacitor charge
   logic [15:0] held_q, held_d;     // sampled value of every pixel
   logic [15:0] dout_q, dout_d;     // word on the output
   logic oe_n_q, oe_n_d;            // output drive, low active
   logic irst_q, irst_d;            // integrator reset switch closed
   logic [9:0] res_q, res_d;        // highest pixel back to sampling
   logic rise;
   logic [16:0] sum;

   // ************************************************************
   // next state
   // ************************************************************
   // one rising pixel clock edge drives every step of the sequence
   always_comb begin
      rise = link.pclk & ~pclk_prev_q;
      sum = {1'b0, acc_q} + {9'h000, light_level};
      pclk_prev_d = link.pclk;
      cnt_d = cnt_q;
      held_d = held_q;
      dout_d = dout_q;
      oe_n_d = oe_n_q;
      irst_d = irst_q;
      res_d = res_q;
      // charge grows only with the reset switch open, and saturates
      if (irst_q) begin
         acc_d = lasq_pkg::ACC_RST;
      end else if (sum[16]) begin
         acc_d = lasq_pkg::ACC_MAX;
      end else begin
         acc_d = sum[15:0];
      end
      if (rise && link.hold) begin
         held_d = acc_q;
      end
      if (rise && link.si) begin
         // new cycle: all pixels held at once, pixel 1 on the output
         cnt_d = 10'h001;
         dout_d = acc_q ^ 16'h0001;
         oe_n_d = 1'b0;
         irst_d = 1'b1;
         res_d = 10'h000;
      end else if (rise && cnt_q != 10'h000) begin
         cnt_d = cnt_q + 10'h001;
         if (cnt_d == lasq_pkg::RELEASE_CLK) begin
            irst_d = 1'b0;
         end
         if (cnt_d >= lasq_pkg::RELEASE_CLK) begin
            res_d = cnt_d - 10'h001;
         end
         if (cnt_d == lasq_pkg::PIX_END) begin
            oe_n_d = 1'b1;
            cnt_d = 10'h000;
         end else begin
            // pixel value carries its index so the order is visible
            dout_d = held_q ^ {6'h00, cnt_d};
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pclk_prev_q <= 1'b0;
         cnt_q <= 10'h000;
         acc_q <= 16'h0000;
         held_q <= 16'h0000;
         dout_q <= 16'h0000;
         oe_n_q <= 1'b1;
         irst_q <= 1'b1;
         res_q <= 10'h000;
      end else begin
         pclk_prev_q <= pclk_prev_d;
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         held_q <= held_d;
         dout_q <= dout_d;
         oe_n_q <= oe_n_d;
         irst_q <= irst_d;
         res_q <= res_d;
      end
   end

   // outputs come straight from the registers
   assign link.aout_data = dout_q;
   assign link.aout_oe_n = oe_n_q;
   assign integrator_reset_switch = irst_q;
   assign sample_switch_resumed = res_q;

endmodule : lasq_sensor
